/* File: verilog/acc_params.svh */
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register addresses on the special function register bus.
`define ACC_ADDR_CTRL 8'h9b
`define ACC_ADDR_MODE 8'h9d
`define ACC_ADDR_MUX 8'h9f

// Control register fields.
`define ACC_CTRL_EN_BIT 7
`define ACC_CTRL_OUT_BIT 6
`define ACC_CTRL_RISE_BIT 5
`define ACC_CTRL_FALL_BIT 4
`define ACC_CTRL_HYP_HI 3
`define ACC_CTRL_HYP_LO 2
`define ACC_CTRL_HYN_HI 1
`define ACC_CTRL_HYN_LO 0

// Mode register fields.
`define ACC_MODE_RISE_IE_BIT 5
`define ACC_MODE_FALL_IE_BIT 4
`define ACC_MODE_RESP_HI 1
`define ACC_MODE_RESP_LO 0

// Input select register fields.
`define ACC_MUX_NEG_HI 7
`define ACC_MUX_NEG_LO 4
`define ACC_MUX_POS_HI 3
`define ACC_MUX_POS_LO 0

// Reset values.
`define ACC_CTRL_RESET 8'h00
`define ACC_MODE_RESET 8'h00
`define ACC_MUX_RESET 8'hff

// Synchroniser depth.
`define ACC_SYNC_STAGES 2

`endif

/* File: verilog/acc_pkg.sv */
package acc_pkg;

  typedef enum logic [1:0] {
    ACC_HYST_OFF = 2'h0,
    ACC_HYST_5MV = 2'h1,
    ACC_HYST_10MV = 2'h2,
    ACC_HYST_20MV = 2'h3
  } acc_hyst_t;

  typedef logic [7:0] acc_byte_t;

endpackage

/* File: verilog/acc_sync.sv */
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_sync
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Raw level from the analog core and the enable that gates it.
  input wire logic async_in,
  input wire logic enable,
  // Gated synchronised level and one-cycle edge pulses.
  output logic sync_out,
  output logic rise_pulse,
  output logic fall_pulse
);

  logic [`ACC_SYNC_STAGES-1:0] stage_reg;
  logic [`ACC_SYNC_STAGES-1:0] stage_next;
  logic gated_reg;
  logic gated_next;

  // The first stage feeds only the second; nothing else looks at it.
  always_comb
  begin
    stage_next = {stage_reg[`ACC_SYNC_STAGES-2:0], async_in};
    gated_next = stage_reg[`ACC_SYNC_STAGES-1] & enable;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage_reg <= '0;
      gated_reg <= 1'b0;
    end
    else
    begin
      stage_reg <= stage_next;
      gated_reg <= gated_next;
    end
  end

  // Edges are taken on the gated level, so enabling can flag a spurious edge.
  assign sync_out = gated_reg;
  assign rise_pulse = gated_next & ~gated_reg;
  assign fall_pulse = ~gated_next & gated_reg;

endmodule

/* File: verilog/acc_top.sv */
`timescale 1ns/1ps
`include "acc_params.svh"


module acc_top
#(
  parameter int POS_SEL_W = 4,
  parameter int NEG_SEL_W = 4,
  parameter int RESP_W = 2
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Special function register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Analog comparator core.
  input wire logic cmp_raw,
  output logic cmp_enable,
  output acc_pkg::acc_hyst_t pos_hysteresis_sel,
  output acc_pkg::acc_hyst_t neg_hysteresis_sel,
  output logic [RESP_W-1:0] response_mode,
  output logic [POS_SEL_W-1:0] pos_input_sel,
  output logic [NEG_SEL_W-1:0] neg_input_sel,
  // Pin crossbar, interrupt and reset controller.
  output logic sync_cmp_out,
  output logic raw_cmp_out,
  output logic cmp_irq,
  output logic cmp_reset_src
);

  // Address decode, shared by the write and read paths.
  function automatic logic [2:0] acc_decode(input logic [7:0] addr);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr == `ACC_ADDR_CTRL)
    begin
      sel = 3'h1;
    end
    else if (addr == `ACC_ADDR_MODE)
    begin
      sel = 3'h2;
    end
    else if (addr == `ACC_ADDR_MUX)
    begin
      sel = 3'h4;
    end
    return sel;
  endfunction

  logic [2:0] wr_sel;
  logic [2:0] rd_sel;

  // Control register state.
  logic enable_reg;
  logic enable_next;
  logic rise_flag_reg;
  logic rise_flag_next;
  logic fall_flag_reg;
  logic fall_flag_next;
  logic [1:0] hyp_reg;
  logic [1:0] hyp_next;
  logic [1:0] hyn_reg;
  logic [1:0] hyn_next;

  // Mode and input select state.
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] mux_reg;
  logic [7:0] mux_next;

  // Registered outputs.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;

  logic sync_level;
  logic rise_pulse;
  logic fall_pulse;
  logic [7:0] ctrl_view;

  acc_sync u_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(cmp_raw),
    .enable(enable_reg),
    .sync_out(sync_level),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  assign wr_sel = sfr_wr ? acc_decode(sfr_addr) : 3'h0;
  assign rd_sel = sfr_rd ? acc_decode(sfr_addr) : 3'h0;

  always_comb
  begin
    enable_next = enable_reg;
    hyp_next = hyp_reg;
    hyn_next = hyn_reg;
    rise_flag_next = rise_flag_reg;
    fall_flag_next = fall_flag_reg;
    if (wr_sel[0])
    begin
      enable_next = sfr_wdata[`ACC_CTRL_EN_BIT];
      hyp_next = sfr_wdata[`ACC_CTRL_HYP_HI:`ACC_CTRL_HYP_LO];
      hyn_next = sfr_wdata[`ACC_CTRL_HYN_HI:`ACC_CTRL_HYN_LO];
      rise_flag_next = sfr_wdata[`ACC_CTRL_RISE_BIT];
      fall_flag_next = sfr_wdata[`ACC_CTRL_FALL_BIT];
    end
    // A hardware edge in the same cycle as a clearing write still wins.
    if (rise_pulse)
    begin
      rise_flag_next = 1'b1;
    end
    if (fall_pulse)
    begin
      fall_flag_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      enable_reg <= 1'(`ACC_CTRL_RESET >> `ACC_CTRL_EN_BIT);
      rise_flag_reg <= 1'b0;
      fall_flag_reg <= 1'b0;
      hyp_reg <= 2'h0;
      hyn_reg <= 2'h0;
    end
    else
    begin
      enable_reg <= enable_next;
      rise_flag_reg <= rise_flag_next;
      fall_flag_reg <= fall_flag_next;
      hyp_reg <= hyp_next;
      hyn_reg <= hyn_next;
    end
  end

  always_comb
  begin
    mode_next = mode_reg;
    mux_next = mux_reg;
    if (wr_sel[1])
    begin
      mode_next = sfr_wdata;
    end
    if (wr_sel[2])
    begin
      mux_next = sfr_wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      mode_reg <= `ACC_MODE_RESET;
      mux_reg <= `ACC_MUX_RESET;
    end
    else
    begin
      mode_reg <= mode_next;
      mux_reg <= mux_next;
    end
  end

  // Bit 6 is taken from the synchroniser; writes never reach it.
  always_comb
  begin
    ctrl_view = {enable_reg, sync_level, rise_flag_reg, fall_flag_reg,
                 hyp_reg, hyn_reg};
    rdata_next = 8'h00;
    if (rd_sel[0])
    begin
      rdata_next = ctrl_view;
    end
    else if (rd_sel[1])
    begin
      rdata_next = {2'h0, mode_reg[`ACC_MODE_RISE_IE_BIT:`ACC_MODE_FALL_IE_BIT], 2'h0,
                    mode_reg[`ACC_MODE_RESP_HI:`ACC_MODE_RESP_LO]};
    end
    else if (rd_sel[2])
    begin
      rdata_next = mux_reg;
    end
    irq_next = (rise_flag_next & mode_next[`ACC_MODE_RISE_IE_BIT])
      | (fall_flag_next & mode_next[`ACC_MODE_FALL_IE_BIT]);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign sfr_rdata = rdata_reg;
  assign cmp_irq = irq_reg;
  assign cmp_enable = enable_reg;
  assign pos_hysteresis_sel = acc_pkg::acc_hyst_t'(hyp_reg);
  assign neg_hysteresis_sel = acc_pkg::acc_hyst_t'(hyn_reg);
  assign response_mode = RESP_W'(mode_reg[`ACC_MODE_RESP_HI:`ACC_MODE_RESP_LO]);
  assign pos_input_sel = POS_SEL_W'(mux_reg[`ACC_MUX_POS_HI:`ACC_MUX_POS_LO]);
  assign neg_input_sel = NEG_SEL_W'(mux_reg[`ACC_MUX_NEG_HI:`ACC_MUX_NEG_LO]);
  assign sync_cmp_out = sync_level;
  // The raw path has no flop so it keeps working while the clock is stopped.
  assign raw_cmp_out = cmp_raw & enable_reg;
  assign cmp_reset_src = sync_level;

endmodule

/* File: bench/acc_core_model.sv */
`timescale 1ns/1ps
// Instant core: response time and hysteresis are not modelled.
module acc_core_model
(
  // Enable from the block and input relation from the bench.
  input wire logic cmp_enable,
  input wire logic pos_above_neg,
  // Result toward the block.
  output logic cmp_raw
);
  // A powered-down core is untrustworthy, so it shows the inverse level.
  assign cmp_raw = cmp_enable ? pos_above_neg : !pos_above_neg;
endmodule

/* File: bench/acc_top_sva.sv */
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_chk
#(
  parameter int POS_SEL_W = 4,
  parameter int NEG_SEL_W = 4,
  parameter int RESP_W = 2
)
(
  // Clock, reset and register bus.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Core and pin side.
  input wire logic cmp_raw,
  input wire logic cmp_enable,
  input wire acc_pkg::acc_hyst_t pos_hysteresis_sel,
  input wire acc_pkg::acc_hyst_t neg_hysteresis_sel,
  input wire logic [RESP_W-1:0] response_mode,
  input wire logic [POS_SEL_W-1:0] pos_input_sel,
  input wire logic [NEG_SEL_W-1:0] neg_input_sel,
  input wire logic sync_cmp_out,
  input wire logic raw_cmp_out,
  input wire logic cmp_reset_src
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_en;
    sfr_wr && sfr_addr == `ACC_ADDR_CTRL |=> cmp_enable == $past(sfr_wdata[7]);
  endproperty
  a_en: assert property (p_en) else $error("enable");
  property p_hys;
    sfr_wr && sfr_addr == `ACC_ADDR_CTRL |=> pos_hysteresis_sel == $past(sfr_wdata[3:2])
      && neg_hysteresis_sel == $past(sfr_wdata[1:0]);
  endproperty
  a_hys: assert property (p_hys) else $error("hysteresis");
  property p_mux;
    sfr_wr && sfr_addr == `ACC_ADDR_MUX |=> {neg_input_sel, pos_input_sel} == $past(sfr_wdata);
  endproperty
  a_mux: assert property (p_mux) else $error("input select");
  property p_mode;
    sfr_wr && sfr_addr == `ACC_ADDR_MODE |=> response_mode == $past(sfr_wdata[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("response mode");
  property p_raw;
    raw_cmp_out == (cmp_raw && cmp_enable);
  endproperty
  a_raw: assert property (p_raw) else $error("raw output");
  property p_off;
    !cmp_enable && !$past(cmp_enable) |-> !sync_cmp_out && !cmp_reset_src;
  endproperty
  a_off: assert property (p_off) else $error("disabled output");
  property p_sync;
    cmp_enable && $past(cmp_enable) && $past(cmp_enable, 2) && $past(cmp_enable, 3)
      |-> sync_cmp_out == $past(cmp_raw, 3) && cmp_reset_src == sync_cmp_out;
  endproperty
  a_sync: assert property (p_sync) else $error("sync output");
  property p_out;
    sfr_rd && sfr_addr == `ACC_ADDR_CTRL |=> sfr_rdata[6] == $past(sync_cmp_out);
  endproperty
  a_out: assert property (p_out) else $error("status bit");
endmodule
bind acc_top acc_chk #(.POS_SEL_W(POS_SEL_W), .NEG_SEL_W(NEG_SEL_W), .RESP_W(RESP_W)) chk
  (.core_clk, .srst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .cmp_raw, .cmp_enable,
  .pos_hysteresis_sel, .neg_hysteresis_sel, .response_mode, .pos_input_sel, .neg_input_sel,
  .sync_cmp_out, .raw_cmp_out, .cmp_reset_src);

/* File: bench/analog_comparator_control_bench.sv */
`timescale 1ns/1ps
`include "acc_params.svh"
module analog_comparator_control_bench;
  logic core_clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, pos_above_neg = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic cmp_raw, cmp_enable, sync_cmp_out, raw_cmp_out, cmp_irq, cmp_reset_src;
  acc_pkg::acc_hyst_t pos_hysteresis_sel, neg_hysteresis_sel;
  logic [1:0] response_mode;
  logic [3:0] pos_input_sel, neg_input_sel;
  int fail_count = 0, total_checks = 0;
  acc_top uut (.core_clk, .srst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .cmp_raw,
    .cmp_enable, .pos_hysteresis_sel, .neg_hysteresis_sel, .response_mode, .pos_input_sel,
    .neg_input_sel, .sync_cmp_out, .raw_cmp_out, .cmp_irq, .cmp_reset_src);
  acc_core_model core (.cmp_enable, .pos_above_neg, .cmp_raw);
  initial forever #25 core_clk = ~core_clk;
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk("sfr_rdata", sfr_rdata, e);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The run needs well under a thousand cycles.
  initial
  begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    rd(`ACC_ADDR_CTRL, `ACC_CTRL_RESET);
    rd(`ACC_ADDR_MUX, `ACC_MUX_RESET);
    rd(8'h9c, 8'h00);
    wr(`ACC_ADDR_MUX, 8'h5a);
    chk("pos_input_sel", pos_input_sel, 8'h0a);
    chk("neg_input_sel", neg_input_sel, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      wr(`ACC_ADDR_CTRL, 8'(i * 4 + 3 - i));
      wr(`ACC_ADDR_MODE, 8'(i));
      chk("pos_hyst", pos_hysteresis_sel, 8'(i));
      chk("neg_hyst", neg_hysteresis_sel, 8'(3 - i));
      chk("response_mode", response_mode, 8'(i));
    end
    rd(`ACC_ADDR_MODE, 8'h03);
    tick(4);
    chk("raw_off", raw_cmp_out, 8'h00);
    chk("sync_off", sync_cmp_out, 8'h00);
    @(posedge core_clk) pos_above_neg <= 1'b1;
    wr(`ACC_ADDR_CTRL, 8'h80);
    chk("cmp_enable", cmp_enable, 8'h01);
    tick(4);
    rd(`ACC_ADDR_CTRL, 8'he0);
    chk("raw_on", raw_cmp_out, 8'h01);
    chk("reset_src", cmp_reset_src, 8'h01);
    wr(`ACC_ADDR_MODE, 8'h20);
    tick(2);
    chk("irq_rise", cmp_irq, 8'h01);
    wr(`ACC_ADDR_CTRL, 8'hc0);
    tick(2);
    chk("irq_clear", cmp_irq, 8'h00);
    @(posedge core_clk) pos_above_neg <= 1'b0;
    #1;
    chk("raw_follow", raw_cmp_out, 8'h00);
    tick(4);
    rd(`ACC_ADDR_CTRL, 8'h90);
    chk("irq_masked", cmp_irq, 8'h00);
    wr(`ACC_ADDR_MODE, 8'h10);
    tick(4);
    chk("irq_fall", cmp_irq, 8'h01);
    rd(`ACC_ADDR_CTRL, 8'h90);
    wr(`ACC_ADDR_CTRL, 8'hc0);
    wr(8'h9c, 8'h00);
    rd(`ACC_ADDR_CTRL, 8'h80);
    wr(`ACC_ADDR_CTRL, 8'h00);
    tick(4);
    chk("sync_disabled", sync_cmp_out, 8'h00);
    finish_test();
  end
endmodule
